/* File: jdrs_data_register_set.sv */
// Test-port data registers, instruction register and configuration word FIFO
`default_nettype none

module jdrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } jdrs_fifo_st_t;
  jdrs_fifo_st_t s;
  jdrs_fifo_st_t next_s;
  logic push;
  logic load;

  // Handshake terms; full stalls the filler
  assign in_ready = s.cnt != CW'(DEPTH);
  assign push = in_valid && in_ready;
  assign load = (s.cnt != '0) && (!s.ov || out_ready);
  assign out_valid = s.ov;
  assign out_data = s.od;

  // Storage, pointers and output stage
  always_comb
  begin
    next_s = s;
    if (out_ready && s.ov)
    begin
      next_s.ov = 1'b0;
    end
    if (load)
    begin
      next_s.od = s.mem[s.rd];
      next_s.ov = 1'b1;
      next_s.rd = s.rd + 1'b1;
    end
    if (push)
    begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = s.wr + 1'b1;
    end
    case ({push, load})
      2'b10: next_s.cnt = s.cnt + 1'b1;
      2'b01: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
    if (sys_rst)
    begin
      next_s = '0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    s <= next_s;
  end
endmodule : jdrs_fifo

module jdrs_data_register_set
  import jdrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Fabric user scan link
  output jdrs_fabric_t fabric,
  input wire logic first_user_scan_out,
  input wire logic second_user_scan_out,
  // Boundary cell sources and update latches
  input wire logic [IO_BLOCKS-1:0] pad_in,
  input wire logic [INPUT_ONLY-1:0] pad_in_only,
  input wire logic [IO_BLOCKS-1:0] core_out,
  input wire logic [IO_BLOCKS-1:0] core_oe,
  output logic [BS_LEN-1:0] bs_hold,
  // Configuration bus
  input wire logic cfg_done,
  input wire logic [ID_W-1:0] design_id_word,
  input wire logic [CFG_W-1:0] cfg_rd_data,
  output logic [CFG_W-1:0] cfg_wr_data,
  output logic cfg_wr_valid,
  input wire logic cfg_wr_ready
);
  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] u1_s;
    logic [1:0] u2_s;
    logic [IO_BLOCKS-1:0] pin_a;
    logic [IO_BLOCKS-1:0] pin_b;
    logic [INPUT_ONLY-1:0] ipin_a;
    logic [INPUT_ONLY-1:0] ipin_b;
    jdrs_tap_t st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic [BS_LEN-1:0] bs;
    logic [BS_LEN-1:0] hold;
    logic byp;
    logic [CFG_W-1:0] cfg;
    logic [ID_W-1:0] word;
    logic tdo;
    logic tdo_oe;
    jdrs_fabric_t fab;
    logic pend;
  } jdrs_st_t;
  jdrs_st_t s;
  jdrs_st_t next_s;
  logic rise;
  logic fall;
  logic fifo_ready;

  // Assertion clock and reset for the checks at the end of the module
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // TCK edges seen on the synchronised level
  assign rise = s.tck_s[1] && !s.tck_s[2];
  assign fall = !s.tck_s[1] && s.tck_s[2];

  // TAP transition on TMS
  function automatic jdrs_tap_t tap_next(input jdrs_tap_t st, input logic m);
    jdrs_tap_t n;
    case (st)
      TAP_RESET: n = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: n = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_IDLE;
      default: n = TAP_RESET;
    endcase
    return n;
  endfunction : tap_next

  // All register behaviour; TAP, capture, shift and update stepped by TCK edges
  always_comb
  begin
    jdrs_dr_t ds;
    logic bit_out;
    ds = jdrs_dr_sel(s.ir, cfg_done);
    bit_out = 1'b0;
    next_s = s;
    next_s.tck_s = {s.tck_s[1:0], tck};
    next_s.tms_s = {s.tms_s[0], tms};
    next_s.tdi_s = {s.tdi_s[0], tdi};
    next_s.u1_s = {s.u1_s[0], first_user_scan_out};
    next_s.u2_s = {s.u2_s[0], second_user_scan_out};
    next_s.pin_a = pad_in;
    next_s.pin_b = s.pin_a;
    next_s.ipin_a = pad_in_only;
    next_s.ipin_b = s.ipin_a;
    // Configuration word leaves once the FIFO takes it
    if (s.pend && fifo_ready)
    begin
      next_s.pend = 1'b0;
    end
    // Rising TCK: capture, shift, advance the TAP
    if (rise)
    begin
      case (s.st)
        TAP_CAP_DR:
        begin
          next_s.byp = 1'b0;
          case (ds)
            DR_BS:
            begin
              for (int k = 0; k < IO_BLOCKS; k++)
              begin
                next_s.bs[CELLS_PER_BLOCK * k + CELL_TRI] = core_oe[k];
                next_s.bs[CELLS_PER_BLOCK * k + CELL_OUT] = core_out[k];
                next_s.bs[CELLS_PER_BLOCK * k + CELL_IN] = s.pin_b[k];
              end
              for (int j = 0; j < INPUT_ONLY; j++)
              begin
                next_s.bs[CELLS_PER_BLOCK * IO_BLOCKS + j] = s.ipin_b[j];
              end
            end
            DR_CFG: next_s.cfg = cfg_rd_data;
            DR_WORD:
            begin
              if (s.ir == INS_PART_ID)
              begin
                next_s.word = PART_ID;
              end
              else
              begin
                next_s.word = cfg_done ? design_id_word : DESIGN_ID_BLANK;
              end
            end
            default: next_s.byp = 1'b0;
          endcase
        end
        TAP_SHIFT_DR:
        begin
          case (ds)
            DR_BS: next_s.bs = {s.tdi_s[1], s.bs[BS_LEN-1:1]};
            DR_CFG: next_s.cfg = {s.tdi_s[1], s.cfg[CFG_W-1:1]};
            DR_WORD: next_s.word = {s.tdi_s[1], s.word[ID_W-1:1]};
            default: next_s.byp = s.tdi_s[1];
          endcase
        end
        TAP_CAP_IR: next_s.ir_sh = {3'h0, cfg_done, IR_FIXED};
        TAP_SHIFT_IR: next_s.ir_sh = {s.tdi_s[1], s.ir_sh[IR_W-1:1]};
        default: next_s.ir_sh = s.ir_sh;
      endcase
      next_s.st = tap_next(s.st, s.tms_s[1]);
    end
    // Falling TCK: drive TDO, open latches, load instruction
    if (fall)
    begin
      case (ds)
        DR_BS: bit_out = s.bs[0];
        DR_CFG: bit_out = s.cfg[0];
        DR_WORD: bit_out = s.word[0];
        DR_U1: bit_out = s.u1_s[1];
        DR_U2: bit_out = s.u2_s[1];
        default: bit_out = s.byp;
      endcase
      next_s.tdo_oe = (s.st == TAP_SHIFT_DR) || (s.st == TAP_SHIFT_IR);
      if (s.st == TAP_SHIFT_IR)
      begin
        next_s.tdo = s.ir_sh[0];
      end
      else if (s.st == TAP_SHIFT_DR)
      begin
        next_s.tdo = bit_out;
      end
      case (s.st)
        TAP_UPD_DR:
        begin
          next_s.hold = s.bs;
          if (s.ir == INS_CFG_WRITE)
          begin
            next_s.pend = 1'b1;
          end
        end
        TAP_UPD_IR: next_s.ir = s.ir_sh;
        TAP_RESET: next_s.ir = INS_PART_ID;
        default: next_s.ir = s.ir;
      endcase
    end
    // Fabric view of the user registers and TAP
    next_s.fab.first_user_select = (ds == DR_U1);
    next_s.fab.second_user_select = (ds == DR_U2);
    next_s.fab.first_user_scan_clock = (ds == DR_U1) && s.tck_s[1] &&
      ((s.st == TAP_CAP_DR) || (s.st == TAP_SHIFT_DR));
    next_s.fab.second_user_scan_clock = (ds == DR_U2) && s.tck_s[1] &&
      ((s.st == TAP_CAP_DR) || (s.st == TAP_SHIFT_DR));
    next_s.fab.tdi = s.tdi_s[1];
    next_s.fab.tap_reset = (s.st == TAP_RESET);
    next_s.fab.tap_shift = (s.st == TAP_SHIFT_DR);
    next_s.fab.tap_update = (s.st == TAP_UPD_DR);
    if (sys_rst)
    begin
      next_s = '0;
      next_s.st = TAP_RESET;
      next_s.ir = INS_PART_ID;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    s <= next_s;
  end

  // Configuration words toward the bus, with back-pressure
  jdrs_fifo #(
    .WIDTH(CFG_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cfg_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(s.pend),
    .in_ready(fifo_ready),
    .in_data(s.cfg),
    .out_valid(cfg_wr_valid),
    .out_ready(cfg_wr_ready),
    .out_data(cfg_wr_data)
  );

  // Outputs straight from state
  assign tdo = s.tdo;
  assign tdo_oe = s.tdo_oe;
  assign fabric = s.fab;
  assign bs_hold = s.hold;

  // Checks on the register behaviour
  a_bypass_clear: assert property (rise && s.st == TAP_CAP_DR |=> !s.byp)
    else $error("bypass bit not cleared in capture");
  a_bypass_shift: assert property (rise && s.st == TAP_SHIFT_DR &&
    jdrs_dr_sel(s.ir, cfg_done) == DR_BYP |=> s.byp == $past(s.tdi_s[1]))
    else $error("bypass bit did not take TDI");
  a_tdo_enable: assert property (fall ##1 !fall |-> s.tdo_oe ==
    ($past(s.st, 2) == TAP_SHIFT_DR || $past(s.st, 2) == TAP_SHIFT_IR))
    else $error("TDO enable wrong after falling TCK");
  a_tdo_falling: assert property (!fall |=> $stable(s.tdo) && $stable(s.tdo_oe))
    else $error("TDO moved without a falling TCK");
  a_hold_load: assert property (fall && s.st == TAP_UPD_DR |=> s.hold == $past(s.bs))
    else $error("update latch missed update state");
  a_hold_steady: assert property (!(fall && s.st == TAP_UPD_DR) |=> $stable(s.hold))
    else $error("update latch moved outside update");
  a_user_blocked: assert property (!cfg_done ##1 !cfg_done |->
    !s.fab.first_user_select && !s.fab.second_user_select)
    else $error("user select before configuration");
  a_select_low: assert property (jdrs_dr_sel(s.ir, cfg_done) != DR_U1 |=>
    !s.fab.first_user_select && !s.fab.first_user_scan_clock)
    else $error("first user select high while inactive");
  a_second_select_low: assert property (jdrs_dr_sel(s.ir, cfg_done) != DR_U2 |=>
    !s.fab.second_user_select && !s.fab.second_user_scan_clock)
    else $error("second user select high while inactive");
  a_ir_status: assert property (rise && s.st == TAP_CAP_IR |=>
    s.ir_sh == {3'h0, $past(cfg_done), IR_FIXED} && (s.st == TAP_EXIT1_IR || s.st == TAP_SHIFT_IR))
    else $error("instruction capture wrong");
  a_id_capture: assert property (rise && s.st == TAP_CAP_DR && s.ir == INS_PART_ID |=>
    s.word[0] && s.word[11:1] == ID_MAKER)
    else $error("part word capture wrong");
endmodule : jdrs_data_register_set
`default_nettype wire

/* File: jdrs_pkg.sv */
// Constants and types shared by the test-port data register set
`default_nettype none
package jdrs_pkg;
  // Chain sizes
  localparam int IR_W = 6;
  localparam int IO_BLOCKS = 4;
  localparam int INPUT_ONLY = 2;
  localparam int CELLS_PER_BLOCK = 3;
  localparam int BS_LEN = CELLS_PER_BLOCK * IO_BLOCKS + INPUT_ONLY;
  localparam int CELL_TRI = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_IN = 2;
  localparam int CFG_W = 64;
  localparam int ID_W = 32;
  localparam int FIFO_DEPTH = 4;
  // Instruction opcodes
  localparam logic [IR_W-1:0] INS_EXTEST = 6'h00;
  localparam logic [IR_W-1:0] INS_SAMPLE = 6'h01;
  localparam logic [IR_W-1:0] INS_FIRST_USER = 6'h02;
  localparam logic [IR_W-1:0] INS_SECOND_USER = 6'h03;
  localparam logic [IR_W-1:0] INS_CFG_READ = 6'h04;
  localparam logic [IR_W-1:0] INS_CFG_WRITE = 6'h05;
  localparam logic [IR_W-1:0] INS_INTEST = 6'h07;
  localparam logic [IR_W-1:0] INS_DESIGN_ID = 6'h08;
  localparam logic [IR_W-1:0] INS_PART_ID = 6'h09;
  localparam logic [IR_W-1:0] INS_BYPASS = 6'h3F;
  // Fixed low bits of the captured instruction status
  localparam logic [1:0] IR_FIXED = 2'h1;
  // Identification fields; values are arbitrary
  localparam logic [3:0] ID_REV = 4'h0;
  localparam logic [6:0] ID_FAMILY = 7'h2A;
  localparam logic [8:0] ID_ROWS = 9'h014;
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic [ID_W-1:0] PART_ID = {ID_REV, ID_FAMILY, ID_ROWS, ID_MAKER, 1'b1};
  localparam logic [ID_W-1:0] DESIGN_ID_BLANK = 32'hFFFFFFFF;
  // TAP states, Gray coded along the data path
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SHIFT_DR = 4'h6, TAP_EXIT1_DR = 4'h7, TAP_PAUSE_DR = 4'h5, TAP_EXIT2_DR = 4'h4,
    TAP_UPD_DR = 4'hC, TAP_SEL_IR = 4'hD, TAP_CAP_IR = 4'hF, TAP_SHIFT_IR = 4'hE,
    TAP_EXIT1_IR = 4'hA, TAP_PAUSE_IR = 4'hB, TAP_EXIT2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } jdrs_tap_t;
  // Selected data register
  typedef enum logic [2:0] {
    DR_BS = 3'h0, DR_BYP = 3'h1, DR_CFG = 3'h2, DR_WORD = 3'h3, DR_U1 = 3'h4, DR_U2 = 3'h5
  } jdrs_dr_t;
  // Signals offered to fabric logic
  typedef struct packed {
    logic first_user_select;
    logic second_user_select;
    logic first_user_scan_clock;
    logic second_user_scan_clock;
    logic tdi;
    logic tap_reset;
    logic tap_shift;
    logic tap_update;
  } jdrs_fabric_t;

  // Data register chosen by an opcode
  function automatic jdrs_dr_t jdrs_dr_sel(input logic [IR_W-1:0] ir, input logic done);
    jdrs_dr_t d;
    case (ir)
      INS_EXTEST, INS_SAMPLE, INS_INTEST: d = DR_BS;
      INS_CFG_READ, INS_CFG_WRITE: d = DR_CFG;
      INS_DESIGN_ID, INS_PART_ID: d = DR_WORD;
      INS_FIRST_USER: d = done ? DR_U1 : DR_BYP;
      INS_SECOND_USER: d = done ? DR_U2 : DR_BYP;
      default: d = DR_BYP;
    endcase
    return d;
  endfunction : jdrs_dr_sel
endpackage : jdrs_pkg
`default_nettype wire

/* File: jdrs_fabric_model.sv */
// Fabric-side model of the two user scan registers
`default_nettype none
module jdrs_fabric_model
  import jdrs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Scan link from the test port
  input wire jdrs_fabric_t fabric,
  output logic first_user_scan_out,
  output logic second_user_scan_out,
  // Word captured by both registers and the words shifted in
  input wire logic [7:0] preset,
  output logic [7:0] got1,
  output logic [7:0] got2
);
  logic clk1_q;
  logic clk2_q;
  logic last1;
  logic last2;

  // Unselected outputs toggle so a stale bit can never pass for data
  assign first_user_scan_out = fabric.first_user_select ? got1[0] : ~last1;
  assign second_user_scan_out = fabric.second_user_select ? got2[0] : ~last2;

  // Capture on a scan clock rise outside shifting, shift on a rise while shifting
  always_ff @(posedge clk)
  begin
    clk1_q <= fabric.first_user_scan_clock;
    clk2_q <= fabric.second_user_scan_clock;
    if (sys_rst)
    begin
      got1 <= 8'h00;
      got2 <= 8'h00;
      last1 <= 1'h0;
      last2 <= 1'h0;
    end
    else
    begin
      last1 <= first_user_scan_out;
      last2 <= second_user_scan_out;
      if (fabric.first_user_scan_clock && !clk1_q)
        got1 <= fabric.tap_shift ? {fabric.tdi, got1[7:1]} : preset;
      if (fabric.second_user_scan_clock && !clk2_q)
        got2 <= fabric.tap_shift ? {fabric.tdi, got2[7:1]} : preset;
    end
  end
endmodule : jdrs_fabric_model
`default_nettype wire

/* File: jdrs_data_register_set_bench.sv */
// Self-checking bench for the test-port data register set
`default_nettype none
module jdrs_data_register_set_bench
  import jdrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic tck = 1'h0;
  logic tms = 1'h1;
  logic tdi = 1'h0;
  logic cfg_done = 1'h0;
  logic cfg_wr_ready = 1'h0;
  logic tdo, tdo_oe, tdo_seen, oe_seen, cfg_wr_valid, first_user_scan_out, second_user_scan_out;
  jdrs_fabric_t fabric;
  logic [IO_BLOCKS-1:0] pad_in = 4'h0, core_out = 4'h0, core_oe = 4'h0;
  logic [INPUT_ONLY-1:0] pad_in_only = 2'h0;
  logic [BS_LEN-1:0] bs_hold;
  logic [ID_W-1:0] design_id_word = 32'h0;
  logic [CFG_W-1:0] cfg_rd_data = 64'h0, cfg_wr_data;
  logic [7:0] preset = 8'h00, got1, got2;
  int fails = 0;
  int n_tests = 0;

  // Design and far-side model
  jdrs_data_register_set i_jdrs_data_register_set (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .fabric(fabric), .first_user_scan_out(first_user_scan_out),
    .second_user_scan_out(second_user_scan_out), .pad_in(pad_in), .pad_in_only(pad_in_only),
    .core_out(core_out), .core_oe(core_oe), .bs_hold(bs_hold), .cfg_done(cfg_done),
    .design_id_word(design_id_word), .cfg_rd_data(cfg_rd_data), .cfg_wr_data(cfg_wr_data),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr_ready(cfg_wr_ready));
  jdrs_fabric_model i_jdrs_fabric_model (.clk(clk), .sys_rst(sys_rst), .fabric(fabric),
    .first_user_scan_out(first_user_scan_out), .second_user_scan_out(second_user_scan_out),
    .preset(preset), .got1(got1), .got2(got2));

  // System clock, 50 ns period
  always #25 clk = ~clk;

  // Compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Counts, verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // One test clock period of 400 ns; TDO is sampled just before the rise
  task automatic pulse(input logic m, input logic d);
    @(posedge clk);
    #2;
    tms = m;
    tdi = d;
    @(posedge clk);
    #2;
    tdo_seen = tdo;
    oe_seen = tdo_oe;
    tck = 1'h1;
    repeat (4) @(posedge clk);
    #2;
    tck = 1'h0;
    repeat (2) @(posedge clk);
    #2;
  endtask : pulse

  // Shift n bits through the instruction or data path, from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = 64'h0;
    pulse(1'h1, 1'h0);
    if (ir)
      pulse(1'h1, 1'h0);
    pulse(1'h0, 1'h0);
    pulse(1'h0, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i]);
      dout[i] = tdo_seen;
      check("tdo_oe shifting", 64'(oe_seen), 64'h1);
      check("tap shift flag", 64'(fabric.tap_shift), 64'(!ir && i < n - 1));
    end
    pulse(1'h1, 1'h0);
    check("tdo_oe after shift", 64'(oe_seen), 64'h0);
    check("tap update flag", 64'(fabric.tap_update), 64'(!ir));
    pulse(1'h0, 1'h0);
  endtask : scan

  // Load an opcode and compare the captured status
  task automatic load_ir(input logic [IR_W-1:0] op);
    logic [63:0] o;
    scan(1'h1, IR_W, 64'(op), o);
    check("ir status", 64'(o[IR_W-1:0]), 64'({3'h0, cfg_done, IR_FIXED}));
  endtask : load_ir

  // Expected boundary capture from pins and core
  function automatic logic [BS_LEN-1:0] chain_exp();
    logic [BS_LEN-1:0] c;
    for (int k = 0; k < IO_BLOCKS; k++)
      c[3*k +: 3] = {pad_in[k], core_out[k], core_oe[k]};
    c[3*IO_BLOCKS +: INPUT_ONLY] = pad_in_only;
    return c;
  endfunction : chain_exp

  // Cut a hang short
  initial
  begin
    repeat (30000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // Test sequence
  initial
  begin
    logic [63:0] o;
    logic [63:0] r;
    logic [63:0] w[5];
    logic [IR_W-1:0] codes[4];
    codes = '{INS_BYPASS, 6'h0A, INS_FIRST_USER, INS_SECOND_USER};
    r = 64'($urandom(80));
    repeat (5) @(posedge clk);
    #2;
    check("reset outputs", 64'({tdo, tdo_oe, fabric, bs_hold, cfg_wr_valid}), 64'h0);
    sys_rst = 1'h0;
    repeat (5) pulse(1'h1, 1'h0);
    check("tap reset flag", 64'(fabric.tap_reset), 64'h1);
    pulse(1'h0, 1'h0);
    scan(1'h0, ID_W, r, o);
    check("part id", 64'(o[ID_W-1:0]), 64'(PART_ID));
    $display("test part id done");
    foreach (codes[k])
    begin
      load_ir(codes[k]);
      r = {$urandom, $urandom};
      scan(1'h0, 16, r, o);
      check("bypass path", 64'(o[15:0]), 64'({r[14:0], 1'h0}));
      check("selects low", 64'({fabric.first_user_select, fabric.second_user_select}), 64'h0);
    end
    $display("test bypass done");
    {pad_in, pad_in_only, core_out, core_oe} = 14'($urandom);
    load_ir(INS_SAMPLE);
    r = {$urandom, $urandom};
    scan(1'h0, BS_LEN + 6, r, o);
    check("sample capture", 64'(o[BS_LEN-1:0]), 64'(chain_exp()));
    check("chain length", 64'(o[BS_LEN+5:BS_LEN]), 64'(r[5:0]));
    check("preload latch", 64'(bs_hold), 64'(r[BS_LEN+5:6]));
    load_ir(INS_EXTEST);
    check("latch held", 64'(bs_hold), 64'(r[BS_LEN+5:6]));
    r = {$urandom, $urandom};
    scan(1'h0, BS_LEN, r, o);
    check("extest capture", 64'(o[BS_LEN-1:0]), 64'(chain_exp()));
    check("extest latch", 64'(bs_hold), 64'(r[BS_LEN-1:0]));
    {pad_in, pad_in_only, core_out, core_oe} = 14'($urandom);
    load_ir(INS_INTEST);
    r = {$urandom, $urandom};
    scan(1'h0, BS_LEN, r, o);
    check("intest capture", 64'(o[BS_LEN-1:0]), 64'(chain_exp()));
    check("intest latch", 64'(bs_hold), 64'(r[BS_LEN-1:0]));
    $display("test boundary done");
    load_ir(INS_DESIGN_ID);
    scan(1'h0, ID_W, r, o);
    check("blank design id", 64'(o[ID_W-1:0]), 64'(DESIGN_ID_BLANK));
    cfg_done = 1'h1;
    design_id_word = $urandom;
    load_ir(INS_DESIGN_ID);
    scan(1'h0, ID_W, r, o);
    check("design id", 64'(o[ID_W-1:0]), 64'(design_id_word));
    load_ir(INS_PART_ID);
    scan(1'h0, ID_W, r, o);
    check("part id loaded", 64'(o[ID_W-1:0]), 64'(PART_ID));
    $display("test design id done");
    for (int k = 0; k < 2; k++)
    begin
      preset = 8'($urandom);
      load_ir(k ? INS_SECOND_USER : INS_FIRST_USER);
      check("user select", 64'({fabric.first_user_select, fabric.second_user_select}),
        64'(k ? 2'h1 : 2'h2));
      r = 64'($urandom);
      scan(1'h0, 8, r, o);
      check("user scan out", 64'(o[7:0]), 64'(preset));
      check("user scan in", 64'(k ? got2 : got1), 64'(r[7:0]));
    end
    $display("test user registers done");
    cfg_rd_data = {$urandom, $urandom};
    load_ir(INS_CFG_READ);
    scan(1'h0, CFG_W, r, o);
    check("readback", o, cfg_rd_data);
    load_ir(INS_CFG_WRITE);
    foreach (w[j])
    begin
      w[j] = {$urandom, $urandom};
      scan(1'h0, CFG_W, w[j], o);
    end
    check("write stalled", 64'(cfg_wr_valid), 64'h1);
    cfg_wr_ready = 1'h1;
    foreach (w[j])
    begin
      for (int t = 0; t < 20 && cfg_wr_valid !== 1'h1; t++)
      begin
        @(posedge clk);
        #2;
      end
      check("write word", cfg_wr_data, w[j]);
      @(posedge clk);
      #2;
    end
    check("write drained", 64'(cfg_wr_valid), 64'h0);
    $display("test configuration done");
    tally_and_finish();
  end
endmodule : jdrs_data_register_set_bench
`default_nettype wire
